//--- logic/spil_defines.vh
// Constants of the serial port interrupt logic
`ifndef SPIL_DEFINES_VH
`define SPIL_DEFINES_VH
`define SPIL_ADDR_ENABLE 3'h1
`define SPIL_ADDR_IDENT 3'h2
`define SPIL_ADDR_SCRATCH 3'h7
`define SPIL_ENABLE_RESET 4'h0
`define SPIL_EN_RX_BIT 0
`define SPIL_EN_TX_BIT 1
`define SPIL_EN_LINE_BIT 2
`define SPIL_EN_MODEM_BIT 3
`define SPIL_CODE_NONE 4'h1
`define SPIL_CODE_LINE 4'h6
`define SPIL_CODE_RX 4'h4
`define SPIL_CODE_TIMEOUT 4'hc
`define SPIL_CODE_TX 4'h2
`define SPIL_CODE_MODEM 4'h0
`define SPIL_MODE_BUFFERED 2'h3
`define SPIL_MODE_CHAR 2'h0
`endif

//--- logic/spil_top.v
// Interrupt ranking, enable register, identification register and scratch byte
`include "spil_defines.vh"

module spil_top (
   input wire CORE_CLK,
   input wire RST,
   input wire CS,
   input wire [2:0] ADDR,
   input wire RD_STB,
   input wire WR_STB,
   input wire [7:0] WR_DATA,
   input wire DIV_LATCH,
   output reg [7:0] RD_DATA,
   output wire RD_VALID,
   input wire LINE_ERR_EVT,
   input wire LINE_STATUS_RD,
   input wire RX_AVAIL,
   input wire RX_TIMEOUT,
   input wire RX_BUF_RD,
   input wire TX_EMPTY_EVT,
   input wire TX_HOLD_WR,
   input wire MODEM_CHG_EVT,
   input wire MODEM_STATUS_RD,
   input wire BUFFERED_MODE,
   input wire IRQ_OUT_ENABLE,
   output wire INT_REQ,
   output wire EXT_IRQ_OUT,
   output wire EXT_IRQ_OE
);

   reg [3:0] enable_r;
   reg [3:0] enable_nxt;
   reg [7:0] scratch_r;
   reg [7:0] scratch_nxt;
   reg line_pend_r;
   reg line_pend_nxt;
   reg tout_pend_r;
   reg tout_pend_nxt;
   reg tx_pend_r;
   reg tx_pend_nxt;
   reg modem_pend_r;
   reg modem_pend_nxt;
   reg [3:0] frozen_code_r;
   reg [3:0] code_nxt;
   reg ident_sel_r;
   reg int_req_r;
   reg int_req_nxt;
   reg [3:0] live_code;
   reg [7:0] rd_data_nxt;
   wire ident_sel;
   wire ident_rd;
   wire en_sel;
   wire en_wr;
   wire en_rd;
   wire scratch_wr;
   wire scratch_rd;
   wire any_rd;
   wire tx_ident_clr;
   wire tx_clr;
   wire code_hold;
   wire gate_on;
   wire line_act;
   wire rx_act;
   wire tout_act;
   wire tx_act;
   wire modem_act;

   // One register select, shared by every address decode below
   function spil_hit;
      input cs;
      input [2:0] addr;
      input [2:0] target;
      begin
         spil_hit = cs && (addr == target);
      end
   endfunction

   // Next value of a latched source; an event in the clearing cycle wins
   function spil_flag_nxt;
      input cur;
      input set;
      input clr;
      begin
         spil_flag_nxt = set || (cur && !clr);
      end
   endfunction

   // Identification byte: mode bits, two zero bits, then code with pending flag
   function [7:0] spil_ident_byte;
      input buffered;
      input [3:0] code;
      begin
         if (buffered) begin
            spil_ident_byte = {`SPIL_MODE_BUFFERED, 2'h0, code};
         end else begin
            spil_ident_byte = {`SPIL_MODE_CHAR, 2'h0, code};
         end
      end
   endfunction

   // Bus decode; the identification address has no write path at all
   assign ident_sel = spil_hit(CS, ADDR, `SPIL_ADDR_IDENT);
   assign ident_rd = ident_sel && RD_STB;
   assign en_sel = spil_hit(CS, ADDR, `SPIL_ADDR_ENABLE) && !DIV_LATCH;
   assign en_wr = en_sel && WR_STB;
   assign en_rd = en_sel && RD_STB;
   assign scratch_wr = spil_hit(CS, ADDR, `SPIL_ADDR_SCRATCH) && WR_STB;
   assign scratch_rd = spil_hit(CS, ADDR, `SPIL_ADDR_SCRATCH) && RD_STB;
   assign any_rd = CS && RD_STB;
   assign RD_VALID = any_rd;

   // Enable register: only the low four bits exist, the rest read zero
   always @* begin
      enable_nxt = enable_r;
      if (en_wr) begin
         enable_nxt = WR_DATA[3:0];
      end
   end

   always @(posedge CORE_CLK) begin
      if (RST) begin
         enable_r <= `SPIL_ENABLE_RESET;
      end else begin
         enable_r <= enable_nxt;
      end
   end

   // Scratch byte is not reset: software must write it before trusting it
   always @* begin
      scratch_nxt = scratch_r;
      if (scratch_wr) begin
         scratch_nxt = WR_DATA;
      end
   end

   always @(posedge CORE_CLK) begin
      scratch_r <= scratch_nxt;
   end

   // Transmit empty drops on an ident read only when it is the one reported
   assign tx_ident_clr = ident_rd && (frozen_code_r == `SPIL_CODE_TX);
   assign tx_clr = TX_HOLD_WR || tx_ident_clr;

   always @* begin
      line_pend_nxt = spil_flag_nxt(line_pend_r, LINE_ERR_EVT, LINE_STATUS_RD);
   end

   always @* begin
      tout_pend_nxt = spil_flag_nxt(tout_pend_r, RX_TIMEOUT, RX_BUF_RD);
   end

   always @* begin
      tx_pend_nxt = spil_flag_nxt(tx_pend_r, TX_EMPTY_EVT, tx_clr);
   end

   always @* begin
      modem_pend_nxt = spil_flag_nxt(modem_pend_r, MODEM_CHG_EVT, MODEM_STATUS_RD);
   end

   always @(posedge CORE_CLK) begin
      if (RST) begin
         line_pend_r <= 1'b0;
      end else begin
         line_pend_r <= line_pend_nxt;
      end
   end

   always @(posedge CORE_CLK) begin
      if (RST) begin
         tout_pend_r <= 1'b0;
      end else begin
         tout_pend_r <= tout_pend_nxt;
      end
   end

   always @(posedge CORE_CLK) begin
      if (RST) begin
         tx_pend_r <= 1'b0;
      end else begin
         tx_pend_r <= tx_pend_nxt;
      end
   end

   // Status flags keep latching even when every source is masked
   always @(posedge CORE_CLK) begin
      if (RST) begin
         modem_pend_r <= 1'b0;
      end else begin
         modem_pend_r <= modem_pend_nxt;
      end
   end

   // Enables count only while the output enable bit is set
   assign gate_on = IRQ_OUT_ENABLE;
   assign line_act = gate_on && enable_r[`SPIL_EN_LINE_BIT] && line_pend_r;
   // Data available is a level from the receive side; it falls with the buffer level
   assign rx_act = gate_on && enable_r[`SPIL_EN_RX_BIT] && RX_AVAIL;
   assign tout_act = gate_on && enable_r[`SPIL_EN_RX_BIT] && tout_pend_r;
   assign tx_act = gate_on && enable_r[`SPIL_EN_TX_BIT] && tx_pend_r;
   assign modem_act = gate_on && enable_r[`SPIL_EN_MODEM_BIT] && modem_pend_r;

   // Fixed priority ranking
   always @* begin
      live_code = `SPIL_CODE_NONE;
      if (line_act) begin
         live_code = `SPIL_CODE_LINE;
      end else if (rx_act) begin
         live_code = `SPIL_CODE_RX;
      end else if (tout_act) begin
         live_code = `SPIL_CODE_TIMEOUT;
      end else if (tx_act) begin
         live_code = `SPIL_CODE_TX;
      end else if (modem_act) begin
         live_code = `SPIL_CODE_MODEM;
      end
   end

   // Freeze from the second selected cycle on so a read never sees the code change mid-access
   assign code_hold = ident_sel && ident_sel_r;

   always @* begin
      code_nxt = live_code;
      int_req_nxt = 1'b0;
      if (code_hold) begin
         code_nxt = frozen_code_r;
      end
      // Pending flag is active low, so the request is its inverse
      int_req_nxt = !code_nxt[0];
   end

   always @(posedge CORE_CLK) begin
      if (RST) begin
         frozen_code_r <= `SPIL_CODE_NONE;
      end else begin
         frozen_code_r <= code_nxt;
      end
   end

   always @(posedge CORE_CLK) begin
      if (RST) begin
         ident_sel_r <= 1'b0;
      end else begin
         ident_sel_r <= ident_sel;
      end
   end

   // Request leaves the same edge as the code, so the two never disagree
   always @(posedge CORE_CLK) begin
      if (RST) begin
         int_req_r <= 1'b0;
      end else begin
         int_req_r <= int_req_nxt;
      end
   end

   assign INT_REQ = int_req_r;
   assign EXT_IRQ_OUT = int_req_r;
   assign EXT_IRQ_OE = IRQ_OUT_ENABLE;

   // Read data is registered; unmapped addresses and a hidden enable read zero
   always @* begin
      rd_data_nxt = RD_DATA;
      if (any_rd) begin
         rd_data_nxt = 8'h00;
         if (en_rd) begin
            rd_data_nxt = {4'h0, enable_r};
         end
         if (ident_rd) begin
            rd_data_nxt = spil_ident_byte(BUFFERED_MODE, frozen_code_r);
         end
         if (scratch_rd) begin
            rd_data_nxt = scratch_r;
         end
      end
   end

   always @(posedge CORE_CLK) begin
      if (RST) begin
         RD_DATA <= 8'h00;
      end else begin
         RD_DATA <= rd_data_nxt;
      end
   end

endmodule

//--- testbench/spil_chk_asserts.sv
// Port checks for the serial port interrupt logic
module spil_chk(input wire CORE_CLK, input wire RST, input wire CS, input wire [2:0] ADDR,
   input wire RD_STB, input wire WR_STB, input wire [7:0] WR_DATA, input wire DIV_LATCH,
   input wire [7:0] RD_DATA, input wire RD_VALID, input wire LINE_ERR_EVT,
   input wire BUFFERED_MODE, input wire IRQ_OUT_ENABLE, input wire INT_REQ,
   input wire EXT_IRQ_OE);
   timeunit 1ns;
   timeprecision 1ns;
   reg [3:0] en_r;
   wire rd1 = CS && RD_STB && ADDR == 3'h1;
   wire rd2 = CS && RD_STB && ADDR == 3'h2;
   // Shadow of the enables, so masking is judged from bus traffic alone
   always @(posedge CORE_CLK)
      if (RST) en_r <= 4'h0;
      else if (CS && WR_STB && ADDR == 3'h1 && !DIV_LATCH) en_r <= WR_DATA[3:0];
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   a_rdv_comb: assert property (RD_VALID == (CS && RD_STB))
      else $error("read valid wrong");
   a_oe_follow: assert property (EXT_IRQ_OE == IRQ_OUT_ENABLE)
      else $error("irq enable pin wrong");
   a_en_read: assert property (rd1 && !DIV_LATCH |=> RD_DATA == {4'h0, $past(en_r)})
      else $error("enable readback wrong");
   a_en_hidden: assert property (rd1 && DIV_LATCH |=> RD_DATA == 8'h00)
      else $error("hidden enable read wrong");
   a_ident_form: assert property (rd2 |=> RD_DATA[5:4] == 2'h0 &&
      RD_DATA[0] == !$past(INT_REQ) && RD_DATA[7:6] == {2{$past(BUFFERED_MODE)}})
      else $error("ident format wrong");
   a_gate_off: assert property (!IRQ_OUT_ENABLE || en_r == 4'h0 |=> !INT_REQ)
      else $error("masked request seen");
   a_line_raise: assert property (LINE_ERR_EVT && en_r[2] && IRQ_OUT_ENABLE && !CS
      ##1 IRQ_OUT_ENABLE && !CS |=> INT_REQ) else $error("line request missing");
   a_rd_hold: assert property (!(CS && RD_STB) |=> $stable(RD_DATA))
      else $error("read data moved");
   a_ident_freeze: assert property (CS && ADDR == 3'h2 ##1 CS && ADDR == 3'h2
      |=> $stable(INT_REQ)) else $error("frozen request moved");
   c_freeze: cover property (CS && ADDR == 3'h2 ##1 rd2);
   c_ident: cover property (rd2 ##1 !RD_DATA[0]);
   c_irq: cover property ($rose(INT_REQ));
   c_hidden: cover property (rd1 && DIV_LATCH);
endmodule
bind spil_top spil_chk u_chk(.*);

//--- testbench/spil_host.sv
// Host model: one register access per call, request held to its taken edge
module spil_host(input wire CORE_CLK, output logic CS, output logic [2:0] ADDR,
   output logic RD_STB, output logic WR_STB, output logic [7:0] WR_DATA);
   timeunit 1ns;
   timeprecision 1ns;
   initial {CS, ADDR, RD_STB, WR_STB, WR_DATA} = 0;
   task acc(input logic w, input logic [2:0] a, input logic [7:0] d);
      @(posedge CORE_CLK);
      {CS, ADDR, WR_STB, RD_STB, WR_DATA} <= {1'b1, a, w, !w, d};
      @(posedge CORE_CLK);
      // Released bus shows the inverse so stale data cannot pass
      {CS, RD_STB, WR_STB, WR_DATA} <= {3'h0, ~d};
   endtask
   // Select held for n edges before the read strobe, as a slow host would
   task acc_held(input logic [2:0] a, input int n);
      @(posedge CORE_CLK);
      {CS, ADDR, WR_STB, RD_STB} <= {1'b1, a, 2'h0};
      repeat (n) @(posedge CORE_CLK);
      RD_STB <= 1'b1;
      @(posedge CORE_CLK);
      {CS, RD_STB} <= 2'h0;
   endtask
endmodule

//--- testbench/test_serial_port_interrupt_logic.sv
// Self-checking bench for the serial port interrupt logic
module test_serial_port_interrupt_logic;
   timeunit 1ns;
   timeprecision 1ns;
   logic CORE_CLK = 0, RST = 1, CS, RD_STB, WR_STB, DIV_LATCH = 0, RX_AVAIL = 0;
   logic BUFFERED_MODE = 0, IRQ_OUT_ENABLE = 0, RD_VALID, INT_REQ, EXT_IRQ_OUT, EXT_IRQ_OE;
   logic [2:0] ADDR;
   logic [7:0] WR_DATA, RD_DATA;
   logic [3:0] ev = 0, clr = 0;
   int err_count = 0, n_tests = 0;
   wire LINE_ERR_EVT = ev[0], RX_TIMEOUT = ev[1], TX_EMPTY_EVT = ev[2], MODEM_CHG_EVT = ev[3];
   wire LINE_STATUS_RD = clr[0], RX_BUF_RD = clr[1], TX_HOLD_WR = clr[2];
   wire MODEM_STATUS_RD = clr[3];
   spil_host host(.*);
   spil_top dut(.*);
   initial forever #50 CORE_CLK = ~CORE_CLK;
   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task rd_chk(input logic [2:0] a, input logic [7:0] e);
      host.acc(1'b0, a, 8'h00);
      #1 chk(RD_DATA, e);
   endtask
   task pulse(input logic [3:0] e, input logic [3:0] c);
      @(posedge CORE_CLK);
      {ev, clr} <= {e, c};
      @(posedge CORE_CLK);
      {ev, clr} <= 8'h00;
   endtask
   task wrap_up;
      $display("comparisons %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #300000;
      err_count++;
      wrap_up;
   end
   initial begin
      repeat (12) @(posedge CORE_CLK);
      RST <= 0;
      rd_chk(3'h2, 8'h01);
      rd_chk(3'h1, 8'h00);
      host.acc(1'b1, 3'h1, 8'hff);
      rd_chk(3'h1, 8'h0f);
      @(posedge CORE_CLK) DIV_LATCH <= 1;
      rd_chk(3'h1, 8'h00);
      @(posedge CORE_CLK) DIV_LATCH <= 0;
      host.acc(1'b1, 3'h7, 8'ha5);
      rd_chk(3'h7, 8'ha5);
      pulse(4'h1, 4'h0);
      rd_chk(3'h2, 8'h01);
      @(posedge CORE_CLK) {IRQ_OUT_ENABLE, RX_AVAIL} <= 2'h3;
      pulse(4'hd, 4'h0);
      rd_chk(3'h2, 8'h06);
      pulse(4'h0, 4'h1);
      rd_chk(3'h2, 8'h04);
      @(posedge CORE_CLK) RX_AVAIL <= 0;
      rd_chk(3'h2, 8'h02);
      rd_chk(3'h2, 8'h00);
      pulse(4'h0, 4'h8);
      rd_chk(3'h2, 8'h01);
      chk({7'h00, INT_REQ}, 8'h00);
      @(posedge CORE_CLK) BUFFERED_MODE <= 1;
      pulse(4'h2, 4'h0);
      rd_chk(3'h2, 8'hcc);
      pulse(4'h0, 4'h2);
      rd_chk(3'h2, 8'hc1);
      host.acc(1'b1, 3'h1, 8'h0b);
      pulse(4'h1, 4'h0);
      rd_chk(3'h2, 8'hc1);
      fork
         host.acc_held(3'h2, 3);
         begin
            @(posedge CORE_CLK);
            pulse(4'h4, 4'h0);
         end
      join
      #1 chk(RD_DATA, 8'hc1);
      chk({7'h00, INT_REQ}, 8'h00);
      rd_chk(3'h2, 8'hc2);
      @(posedge CORE_CLK) RST <= 1;
      repeat (2) @(posedge CORE_CLK);
      RST <= 0;
      rd_chk(3'h1, 8'h00);
      rd_chk(3'h2, 8'hc1);
      host.acc(1'b1, 3'h1, 8'h00);
      wrap_up;
   end
endmodule
